// *** rtl/lepc_ctrl.sv ***
// Energy-sensing power control of the transceiver line circuitry.
// Assumes register strobes from management logic on core_clk, and raw
// energy detector levels from the analog front end (asynchronous).
`timescale 1ns/10ps
`include "lepc_cfg.svh"

// How it works
// - Energy mode acts only while enable bit set
// - Auto wake once data count reaches threshold
// - Auto sleep when line shows no energy
// - Manual bit flips state, then self-clears
// - Four pulses on power-up, one if single
// - Power flag reads current up/down state
// - Error threshold flag, clear on read, informational
// - Data threshold flag set, clear on read
// - Error threshold field, reset value one
// - Data threshold field, reset value one
// - Counters clear after two idle seconds
module lepc_ctrl #(
    parameter int unsigned IDLE_CYCLES = `LEPC_IDLE_MS * `LEPC_CLK_KHZ,
    parameter int unsigned CNT_W       = 4
) (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire logic [`LEPC_ADDR_W-1:0] reg_addr,
    input  wire logic                    reg_wr_en,
    input  wire logic [15:0]             reg_wr_data,
    input  wire logic                    reg_rd_en,
    output logic      [15:0]             reg_rd_data,
    input  wire lepc_pkg::lepc_evt_t     evt_raw,
    output logic                         line_drv_on,
    output logic                         ed_pulse
);
    import lepc_pkg::*;

    localparam int unsigned TW = $clog2(IDLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    ////////////////////////////////////////////////////////////////////////
    // Detector inputs cross into core_clk through two flops

    lepc_evt_t sync1;
    lepc_evt_t sync2;
    lepc_evt_t evt_q;
    lepc_evt_t next_sync1;
    lepc_evt_t next_sync2;
    lepc_evt_t next_evt_q;
    logic      data_evt;
    logic      err_evt;

    always_comb begin
        next_sync1 = evt_raw;
        next_sync2 = sync1;
        next_evt_q = sync2;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= '0;
            sync2 <= '0;
            evt_q <= '0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            evt_q <= next_evt_q;
        end
    end

    // Events are rising edges of the synchronised detector levels
    assign data_evt = sync2.data & ~evt_q.data;
    assign err_evt  = sync2.err & ~evt_q.err;

    ////////////////////////////////////////////////////////////////////////
    // Register, counters, power state and pulse burst

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        sat_inc = (c == CNT_MAX) ? c : c + 1'b1;
    endfunction

    lepc_ctrl_t       ctrl;
    lepc_ctrl_t       next_ctrl;
    lepc_state_t      state;
    lepc_state_t      next_state;
    logic             man;
    logic             next_man;
    logic             err_hit;
    logic             next_err_hit;
    logic             data_hit;
    logic             next_data_hit;
    logic [CNT_W-1:0] data_cnt;
    logic [CNT_W-1:0] next_data_cnt;
    logic [CNT_W-1:0] err_cnt;
    logic [CNT_W-1:0] next_err_cnt;
    logic [TW-1:0]    idle_cnt;
    logic [TW-1:0]    next_idle_cnt;
    logic [2:0]       burst_left;
    logic [2:0]       next_burst_left;
    logic [1:0]       gap;
    logic [1:0]       next_gap;
    logic             next_ed_pulse;
    logic [15:0]      next_rd_data;
    logic             hit;
    logic             idle_done;
    logic             data_set;
    logic             err_set;
    logic             data_reach;

    assign hit        = (reg_addr == `LEPC_ADDR);
    assign idle_done  = (idle_cnt == TW'(IDLE_CYCLES - 1));
    // Fields widen to the counter width; CNT_W must not be below 4
    assign data_reach = (CNT_W'(ctrl.data_lim) <= data_cnt);
    assign data_set   = data_evt &&
        (CNT_W'(ctrl.data_lim) <= sat_inc(data_cnt));
    assign err_set    = err_evt &&
        (CNT_W'(ctrl.err_lim) <= sat_inc(err_cnt));

    always_comb begin
        next_ctrl       = ctrl;
        next_man        = 1'b0;  // Self-clears one cycle after the write
        next_state      = state;
        next_data_cnt   = data_cnt;
        next_err_cnt    = err_cnt;
        next_idle_cnt   = idle_cnt;
        next_burst_left = burst_left;
        next_gap        = gap;
        next_ed_pulse   = 1'b0;
        next_rd_data    = reg_rd_data;
        next_err_hit    = err_hit;
        next_data_hit   = data_hit;

        if (reg_wr_en && hit) begin
            next_ctrl.en        = reg_wr_data[`LEPC_BIT_EN];
            next_ctrl.auto_up   = reg_wr_data[`LEPC_BIT_AUTO_UP];
            next_ctrl.auto_down = reg_wr_data[`LEPC_BIT_AUTO_DOWN];
            next_ctrl.single    = reg_wr_data[`LEPC_BIT_SINGLE];
            next_ctrl.err_lim   =
                reg_wr_data[`LEPC_ERR_MSB:`LEPC_ERR_LSB];
            next_ctrl.data_lim  =
                reg_wr_data[`LEPC_DATA_MSB:`LEPC_DATA_LSB];
            next_man            = reg_wr_data[`LEPC_BIT_MAN];
        end

        if (reg_rd_en && hit) begin
            next_rd_data = '0;
            next_rd_data[`LEPC_BIT_EN]        = ctrl.en;
            next_rd_data[`LEPC_BIT_AUTO_UP]   = ctrl.auto_up;
            next_rd_data[`LEPC_BIT_AUTO_DOWN] = ctrl.auto_down;
            next_rd_data[`LEPC_BIT_MAN]       = man;
            next_rd_data[`LEPC_BIT_SINGLE]    = ctrl.single;
            next_rd_data[`LEPC_BIT_PWR]       = (state == LEPC_UP);
            next_rd_data[`LEPC_BIT_ERR_HIT]   = err_hit;
            next_rd_data[`LEPC_BIT_DATA_HIT]  = data_hit;
            next_rd_data[`LEPC_ERR_MSB:`LEPC_ERR_LSB]   = ctrl.err_lim;
            next_rd_data[`LEPC_DATA_MSB:`LEPC_DATA_LSB] = ctrl.data_lim;
            next_err_hit  = 1'b0;
            next_data_hit = 1'b0;
        end
        // Set beats clear so an event in the read cycle is not lost
        if (err_set) begin
            next_err_hit = 1'b1;
        end
        if (data_set) begin
            next_data_hit = 1'b1;
        end

        if (data_evt) begin
            next_data_cnt = sat_inc(data_cnt);
            next_idle_cnt = '0;
        end else if (idle_done) begin
            next_data_cnt = '0;
            next_err_cnt  = '0;
            next_idle_cnt = '0;
        end else begin
            next_idle_cnt = idle_cnt + 1'b1;
        end
        if (err_evt && !idle_done) begin
            next_err_cnt = sat_inc(err_cnt);
        end

        // Error threshold never drives a power action
        if (ctrl.en) begin
            case (state)
                LEPC_DOWN: begin
                    if (man || (ctrl.auto_up && data_reach)) begin
                        next_state = LEPC_UP;
                    end
                end
                LEPC_UP: begin
                    if (man || (ctrl.auto_down && evt_q.silent)) begin
                        next_state = LEPC_DOWN;
                    end
                end
                default: next_state = LEPC_DOWN;
            endcase
        end

        // Burst of energy pulses each time the driver powers up
        if (next_state == LEPC_UP && state != LEPC_UP) begin
            next_burst_left = ctrl.single ? 3'h1 : `LEPC_BURST_LEN;
            next_gap        = '0;
        end else if (state != LEPC_UP) begin
            next_burst_left = '0;  // Powering down aborts a burst
        end else if (burst_left != '0) begin
            if (gap == '0) begin
                next_ed_pulse   = 1'b1;
                next_burst_left = burst_left - 1'b1;
                next_gap        = `LEPC_BURST_GAP - 2'h1;
            end else begin
                next_gap = gap - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl.en        <= `LEPC_RST_EN;
            ctrl.auto_up   <= `LEPC_RST_AUTO_UP;
            ctrl.auto_down <= `LEPC_RST_AUTO_DOWN;
            ctrl.single    <= `LEPC_RST_SINGLE;
            ctrl.err_lim   <= `LEPC_RST_ERR_LIM;
            ctrl.data_lim  <= `LEPC_RST_DATA_LIM;
            man            <= 1'b0;
            state          <= LEPC_DOWN;
            data_cnt       <= '0;
            err_cnt        <= '0;
            idle_cnt       <= '0;
            burst_left     <= '0;
            gap            <= '0;
            ed_pulse       <= 1'b0;
            reg_rd_data    <= '0;
            err_hit        <= 1'b0;
            data_hit       <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            man         <= next_man;
            state       <= next_state;
            data_cnt    <= next_data_cnt;
            err_cnt     <= next_err_cnt;
            idle_cnt    <= next_idle_cnt;
            burst_left  <= next_burst_left;
            gap         <= next_gap;
            ed_pulse    <= next_ed_pulse;
            reg_rd_data <= next_rd_data;
            err_hit     <= next_err_hit;
            data_hit    <= next_data_hit;
        end
    end

    // Meaningless while disabled, as the power flag is
    assign line_drv_on = (state == LEPC_UP);

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_disabled_hold;
        @(posedge core_clk) disable iff (!nrst)
        !ctrl.en |=> $stable(state);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold)
        else $error("state moved while energy mode disabled");

    property p_auto_wake;
        @(posedge core_clk) disable iff (!nrst)
        ctrl.en && ctrl.auto_up && state == LEPC_DOWN && data_reach
        |=> state == LEPC_UP;
    endproperty
    a_auto_wake: assert property (p_auto_wake)
        else $error("no wake at data threshold");

    property p_auto_sleep;
        @(posedge core_clk) disable iff (!nrst)
        ctrl.en && ctrl.auto_down && state == LEPC_UP && evt_q.silent
        |=> state == LEPC_DOWN;
    endproperty
    a_auto_sleep: assert property (p_auto_sleep)
        else $error("no sleep on silent line");

    property p_manual;
        @(posedge core_clk) disable iff (!nrst)
        reg_wr_en && hit && reg_wr_data[`LEPC_BIT_MAN] && next_ctrl.en
        |=> ##1 (state != $past(state, 2)) && !man;
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual toggle did not flip state or self-clear");

    sequence s_four_pulses;
        ed_pulse ##1 !ed_pulse ##1 ed_pulse ##1 !ed_pulse ##1 ed_pulse
        ##1 !ed_pulse ##1 ed_pulse ##1 !ed_pulse[*2];
    endsequence
    // A power-down inside the burst aborts it, so that also passes
    property p_burst;
        @(posedge core_clk) disable iff (!nrst)
        $rose(line_drv_on) && !ctrl.single |->
        (##1 s_four_pulses) or (##[1:9] !line_drv_on);
    endproperty
    a_burst: assert property (p_burst)
        else $error("power-up burst is not four pulses");

    property p_pwr_flag;
        @(posedge core_clk) disable iff (!nrst)
        reg_rd_en && hit |=> reg_rd_data[`LEPC_BIT_PWR] == $past(line_drv_on);
    endproperty
    a_pwr_flag: assert property (p_pwr_flag)
        else $error("power flag read wrong");

    property p_err_hit;
        @(posedge core_clk) disable iff (!nrst)
        err_set |=> err_hit;
    endproperty
    a_err_hit: assert property (p_err_hit)
        else $error("error flag not set at threshold");

    property p_err_rd;
        @(posedge core_clk) disable iff (!nrst)
        reg_rd_en && hit && err_hit |=> reg_rd_data[`LEPC_BIT_ERR_HIT];
    endproperty
    a_err_rd: assert property (p_err_rd)
        else $error("error flag not reported by read");
    property p_err_clear;
        @(posedge core_clk) disable iff (!nrst)
        reg_rd_en && hit && !err_set |=> !err_hit;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error flag not cleared by read");

    property p_data_hit;
        @(posedge core_clk) disable iff (!nrst)
        data_set |=> data_hit;
    endproperty
    a_data_hit: assert property (p_data_hit)
        else $error("data flag not set at threshold");

    property p_data_rd;
        @(posedge core_clk) disable iff (!nrst)
        reg_rd_en && hit && data_hit |=> reg_rd_data[`LEPC_BIT_DATA_HIT];
    endproperty
    a_data_rd: assert property (p_data_rd)
        else $error("data flag not reported by read");

    property p_idle_clear;
        @(posedge core_clk) disable iff (!nrst)
        idle_done && !data_evt |=> data_cnt == '0 && err_cnt == '0;
    endproperty
    a_idle_clear: assert property (p_idle_clear)
        else $error("counters not cleared after idle interval");

    property p_saturate;
        @(posedge core_clk) disable iff (!nrst)
        data_cnt == CNT_MAX && data_evt |=> data_cnt == CNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("data counter wrapped");

endmodule

// *** rtl/lepc_cfg.svh ***
// Constants of the line energy power control block: register offset,
// field positions, reset values and timing counts.
// Assumes a 5-bit management register address and a 50 MHz core clock.
`ifndef LEPC_CFG_SVH
`define LEPC_CFG_SVH

`define LEPC_ADDR_W         5
`define LEPC_ADDR           5'h1d
`define LEPC_BIT_EN         15
`define LEPC_BIT_AUTO_UP    14
`define LEPC_BIT_AUTO_DOWN  13
`define LEPC_BIT_MAN        12
`define LEPC_BIT_SINGLE     11
`define LEPC_BIT_PWR        10
`define LEPC_BIT_ERR_HIT    9
`define LEPC_BIT_DATA_HIT   8
`define LEPC_ERR_MSB        7
`define LEPC_ERR_LSB        4
`define LEPC_DATA_MSB       3
`define LEPC_DATA_LSB       0
`define LEPC_RST_EN         1'b0
`define LEPC_RST_AUTO_UP    1'b1
`define LEPC_RST_AUTO_DOWN  1'b1
`define LEPC_RST_SINGLE     1'b0
`define LEPC_RST_ERR_LIM    4'h1
`define LEPC_RST_DATA_LIM   4'h1
`define LEPC_CLK_KHZ        50000
`define LEPC_IDLE_MS        2000
`define LEPC_BURST_LEN      3'h4
`define LEPC_BURST_GAP      2'h2

`endif

// *** rtl/lepc_pkg.sv ***
// Types of the line energy power control block.
// Field positions and reset values live in lepc_cfg.svh.
package lepc_pkg;

    typedef struct packed {
        logic       en;
        logic       auto_up;
        logic       auto_down;
        logic       single;
        logic [3:0] err_lim;
        logic [3:0] data_lim;
    } lepc_ctrl_t;

    typedef struct packed {
        logic data;
        logic err;
        logic silent;
    } lepc_evt_t;

    typedef enum logic {
        LEPC_DOWN,
        LEPC_UP
    } lepc_state_t;

endpackage

// *** testbench/lepc_line_model.sv ***
// Cable energy model: raises raw data and error detector levels and holds
// the silence level. Assumes the bench calls its tasks, one at a time.
`timescale 1ns/10ps

module lepc_line_model (
    input  wire logic          core_clk,
    output lepc_pkg::lepc_evt_t evt_raw
);
    import lepc_pkg::*;

    initial begin
        evt_raw = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One event is one rising level; low again for len cycles so that the
    // detector can see the next rise. len varies between prompt and slow.
    task automatic pulse(input bit err, input int len);
        @(negedge core_clk);
        if (err) begin
            evt_raw.err = 1'b1;
        end else begin
            evt_raw.data = 1'b1;
        end
        repeat (len) @(negedge core_clk);
        evt_raw.data = 1'b0;
        evt_raw.err  = 1'b0;
        repeat (len) @(negedge core_clk);
    endtask

    task automatic set_silent(input logic s);
        @(negedge core_clk);
        evt_raw.silent = s;
    endtask
endmodule

// *** testbench/lepc_ctrl_tb.sv ***
// Self-checking bench of the energy power control block.
// Assumes the cfg header on the include path; idle timer shortened to 50.
`timescale 1ns/10ps
`include "lepc_cfg.svh"

module lepc_ctrl_tb;
    import lepc_pkg::*;

`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin fails++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end

    logic        core_clk    = 1'b0;
    logic        nrst        = 1'b0;
    logic [4:0]  reg_addr    = 5'h00;
    logic        reg_wr_en   = 1'b0;
    logic        reg_rd_en   = 1'b0;
    logic [15:0] reg_wr_data = 16'h0000;
    logic [15:0] reg_rd_data;
    lepc_evt_t   evt_raw;
    logic        line_drv_on;
    logic        ed_pulse;
    logic        rd_took     = 1'b0;
    logic [31:0] expq[$];
    logic [31:0] ent;
    logic [15:0] v;
    int          fails       = 0;
    int          checks      = 0;
    int          cyc         = 0;
    int          pulses      = 0;
    int          seed        = 39;

    always #10 core_clk = ~core_clk;

    lepc_ctrl #(.IDLE_CYCLES(50), .CNT_W(4)) uut (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .reg_addr    (reg_addr),
        .reg_wr_en   (reg_wr_en),
        .reg_wr_data (reg_wr_data),
        .reg_rd_en   (reg_rd_en),
        .reg_rd_data (reg_rd_data),
        .evt_raw     (evt_raw),
        .line_drv_on (line_drv_on),
        .ed_pulse    (ed_pulse)
    );

    lepc_line_model line (
        .core_clk (core_clk),
        .evt_raw  (evt_raw)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard well above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        rd_took <= reg_rd_en && reg_addr == `LEPC_ADDR;
        if (ed_pulse === 1'b1) pulses <= pulses + 1;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            conclude();
        end
    end

    // Read data is registered, so it is settled by the next falling edge
    always @(negedge core_clk) begin
        if (rd_took && expq.size() > 0) begin
            ent = expq.pop_front();
            `CHK("reg_rd_data", ent[15:0], reg_rd_data & ent[31:16])
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_addr    = a;
        reg_wr_data = d;
        reg_wr_en   = 1'b1;
        @(negedge core_clk);
        reg_wr_en   = 1'b0;
        @(negedge core_clk);
    endtask

    // Flags and the self-clearing bit are masked where they are not known
    task automatic rd(input logic [4:0] a, input logic [15:0] e,
                      input logic [15:0] m);
        if (a == `LEPC_ADDR) expq.push_back({m, e & m});
        @(negedge core_clk);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic wait_drv(input logic e);
        int i;
        for (i = 0; i < 30 && line_drv_on !== e; i++) @(negedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        rd(`LEPC_ADDR, 16'h6011, 16'hffff);
        wr(5'h1c, 16'hffff);
        rd(5'h1c, 16'h0000, 16'h0000);
        `CHK("unmapped read", 16'h6011, reg_rd_data)
        rd(`LEPC_ADDR, 16'h6011, 16'hffff);
        $display("test reset_and_unmapped done");

        for (int k = 0; k < 3; k++) begin
            v = 16'($random(seed));
            v[15] = 1'b0;
            wr(`LEPC_ADDR, v);
            line.pulse(1'b0, 3 + k);
            `CHK("drv off when disabled", 1'b0, line_drv_on)
            rd(`LEPC_ADDR, v, 16'he8ff);
        end
        repeat (60) @(negedge core_clk);
        $display("test disabled done");

        wr(`LEPC_ADDR, 16'he011);
        pulses = 0;
        line.pulse(1'b0, 4);
        wait_drv(1'b1);
        `CHK("auto wake", 1'b1, line_drv_on)
        repeat (20) @(negedge core_clk);
        `CHK("burst pulses", 4, pulses)
        rd(`LEPC_ADDR, 16'he511, 16'hffff);
        rd(`LEPC_ADDR, 16'he411, 16'hffff);
        repeat (60) @(negedge core_clk);
        line.set_silent(1'b1);
        wait_drv(1'b0);
        `CHK("auto sleep", 1'b0, line_drv_on)
        rd(`LEPC_ADDR, 16'he011, 16'hffff);
        line.set_silent(1'b0);
        $display("test wake_sleep done");

        wr(`LEPC_ADDR, 16'he813);
        pulses = 0;
        line.pulse(1'b0, 3);
        line.pulse(1'b0, 3);
        repeat (60) @(negedge core_clk);
        line.pulse(1'b0, 5);
        line.pulse(1'b0, 5);
        `CHK("below threshold", 1'b0, line_drv_on)
        line.pulse(1'b0, 3);
        wait_drv(1'b1);
        `CHK("wake at threshold", 1'b1, line_drv_on)
        repeat (20) @(negedge core_clk);
        `CHK("single pulse", 1, pulses)
        rd(`LEPC_ADDR, 16'hed13, 16'hffff);
        $display("test threshold done");

        // Software picks the moment of the power change itself
        wr(`LEPC_ADDR, 16'hb813);
        wait_drv(1'b0);
        `CHK("manual down", 1'b0, line_drv_on)
        rd(`LEPC_ADDR, 16'ha813, 16'hffff);
        line.pulse(1'b1, 4);
        repeat (10) @(negedge core_clk);
        `CHK("error no action", 1'b0, line_drv_on)
        rd(`LEPC_ADDR, 16'haa13, 16'hffff);
        rd(`LEPC_ADDR, 16'ha813, 16'hffff);
        $display("test manual_error done");
        conclude();
    end
endmodule
